// ==== include/led_scan_pkg.sv ====
// constants for the led matrix scan and pwm control block
// assumes a 100 MHz core clock and a byte-wide internal register port
package led_scan_pkg;
  localparam int unsigned CLK_MHZ = 100;
  // register offsets
  localparam logic [7:0] ADDR_CONFIG = 8'h50;
  localparam logic [7:0] ADDR_GCURRENT = 8'h51;
  localparam logic [7:0] ADDR_PULLSEL = 8'h52;
  localparam logic [7:0] ADDR_FAULT_FIRST = 8'h53;
  localparam logic [7:0] ADDR_FAULT_LAST = 8'h5e;
  localparam logic [7:0] ADDR_THERMAL = 8'h5f;
  localparam logic [7:0] ADDR_SPREAD = 8'h60;
  localparam logic [7:0] ADDR_SOFT_RESET = 8'h8f;
  localparam logic [7:0] ADDR_RATE_UNLOCK = 8'he0;
  localparam logic [7:0] ADDR_RATE_SELECT = 8'he2;
  localparam logic [7:0] SOFT_RESET_KEY = 8'hae;
  // reset values
  localparam logic [7:0] RST_CONFIG = 8'h00;
  localparam logic [7:0] RST_GCURRENT = 8'h00;
  localparam logic [7:0] RST_PULLSEL = 8'h33;
  localparam logic [7:0] RST_ZERO = 8'h00;
  // field positions
  localparam int unsigned CFG_SHUTDOWN_BIT = 0;
  localparam int unsigned CFG_DETECT_LSB = 1;
  localparam int unsigned CFG_ROWSEL_LSB = 4;
  localparam int unsigned SPREAD_EN_BIT = 4;
  localparam int unsigned RATE_CODE_LSB = 5;
  localparam int unsigned FAULT_COLS = 6;
  localparam int unsigned FAULT_REGS = 12;
  localparam int unsigned ROWS = 4;
  localparam logic [1:0] DETECT_OPEN = 2'h1;
  localparam logic [1:0] DETECT_SHORT = 2'h2;
  localparam logic [3:0] ROWSEL_NO_SCAN = 4'h3;
  localparam logic [3:0] ROWSEL_THREE = 4'h1;
  localparam logic [3:0] ROWSEL_TWO = 4'h2;
  // scan timing, in nanoseconds, and derived cycle counts
  localparam int unsigned SCAN_NS = 33000;
  localparam int unsigned BLANK_A_NS = 830;
  localparam int unsigned BLANK_B_NS = 300;
  localparam int unsigned SCAN_CYC = (SCAN_NS * CLK_MHZ) / 1000;
  localparam int unsigned BLANK_A_CYC = (BLANK_A_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned BLANK_B_CYC = (BLANK_B_NS * CLK_MHZ + 999) / 1000;
  // pwm step counts
  localparam int unsigned PWM_STEPS = 256;
  localparam logic [2:0] RATE_SLOWEST = 3'h6;
  // slot phases, one-hot
  typedef enum logic [2:0] {
    PH_SCAN = 3'b001,
    PH_BLANK_A = 3'b010,
    PH_BLANK_B = 3'b100
  } phase_t;
endpackage

// ==== tb/led_host_model.sv ====
// host side model: drives the byte register port of the matrix block
// assumes strobes are sampled on the rising edge of i_ref_clk
`timescale 1ns/1ps
`default_nettype none
module led_host_model (
  input wire logic i_ref_clk, // core clock
  input wire logic [7:0] i_rdata, // read data from device
  input wire logic i_rd_valid, // read data valid pulse
  output logic o_wr_en, // write strobe
  output logic o_rd_en, // read strobe
  output logic [7:0] o_addr, // register address
  output logic [7:0] o_wdata // write data
);
  import led_scan_pkg::*;
  // idle port after power-up
  initial begin
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    o_addr = 8'h00;
    o_wdata = 8'h00;
  end
  // one write; released lines show the inverse so stale values are never trusted
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    #1;
    o_wr_en = 1'b1;
    o_addr = a;
    o_wdata = d;
    @(posedge i_ref_clk);
    #1;
    o_wr_en = 1'b0;
    o_addr = ~a;
    o_wdata = ~d;
  endtask
  // one read; data is taken while the valid pulse stands
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_ref_clk);
    #1;
    o_rd_en = 1'b1;
    o_addr = a;
    @(posedge i_ref_clk);
    #1;
    o_rd_en = 1'b0;
    o_addr = ~a;
    d = i_rd_valid ? i_rdata : 8'hxx;
  endtask
  // detection setup: current in range, pulls off, clear then set
  task automatic detect(input logic [1:0] code);
    wr(ADDR_GCURRENT, 8'h20);
    wr(ADDR_PULLSEL, 8'h00);
    wr(ADDR_CONFIG, 8'h01);
    wr(ADDR_CONFIG, {5'h00, code, 1'b1});
  endtask
  // soft reset by key write
  task automatic soft_reset();
    wr(ADDR_SOFT_RESET, SOFT_RESET_KEY);
  endtask
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
// self-checking bench for the led matrix scan and pwm control block
// assumes the host model in led_host_model.sv and a 100 MHz clock
`timescale 1ns/1ps
`default_nettype none
module tb;
  import led_scan_pkg::*;
  localparam int SLOT = SCAN_CYC + BLANK_A_CYC + BLANK_B_CYC;
  localparam int STEP = SCAN_CYC / PWM_STEPS; // cycles per pwm step at rate code 0
  logic ref_clk = 1'b0; // core clock
  logic resetn; // active low reset
  logic wr_en, rd_en, rd_valid, over_temp, sink, sen;
  logic [7:0] addr, wdata, rdata, pwm_value, rv;
  logic [5:0] sink_fault; // analog fault sense stand-in
  logic [3:0] rows, cur;
  logic [1:0] thr, scale, srange, scycle;
  logic [2:0] rate;
  int miscompares = 0;
  int n_tests = 0;
  int n, s, r;
  logic [7:0] n_g [3] = '{8'd0, 8'd116, 8'd255}; // gamma table points: dark, mid, full
  led_host_model host (.i_ref_clk(ref_clk), .i_rdata(rdata), .i_rd_valid(rd_valid),
    .o_wr_en(wr_en), .o_rd_en(rd_en), .o_addr(addr), .o_wdata(wdata));
  led_matrix_scan_pwm_control #(.DIV_W(10)) dut (.i_ref_clk(ref_clk), .i_resetn(resetn),
    .i_wr_en(wr_en), .i_rd_en(rd_en), .i_addr(addr), .i_wdata(wdata),
    .i_pwm_value(pwm_value), .i_sink_fault(sink_fault), .i_over_temp(over_temp),
    .o_rdata(rdata), .o_rd_valid(rd_valid), .o_row_switch_output(rows),
    .o_column_sink_output(sink), .o_rolloff_threshold(thr), .o_current_scale(scale),
    .o_spread_enable(sen), .o_spread_range(srange), .o_spread_cycle(scycle),
    .o_pwm_rate_code(rate));
  // free running clock, 10 ns period
  always #5 ref_clk = ~ref_clk;
  task automatic close_out();
    if (miscompares == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rdcheck(input logic [7:0] a, input logic [7:0] exp);
    host.rd(a, rv);
    check({8'h00, rv}, {8'h00, exp});
  endtask
  // step past the edge so registered outputs have landed
  task automatic tick();
    @(posedge ref_clk);
    #1;
  endtask
  // cycles spent with rows at v, bounded
  task automatic wait_while(input logic [3:0] v, input int lim, output int k);
    k = 0;
    while (rows === v && k < lim) begin
      tick();
      k++;
    end
  endtask
  // count sink-on and row-on cycles over a window
  task automatic sample(input int lim, output int sc, output int rc);
    sc = 0;
    rc = 0;
    repeat (lim) begin
      tick();
      sc += (sink === 1'b1) ? 1 : 0;
      rc += (rows !== 4'h0) ? 1 : 0;
    end
  endtask
  // watchdog: longer than the whole sequence should ever take
  initial begin
    #1_200_000;
    miscompares++;
    close_out();
  end
  // main sequence
  initial begin
    resetn = 1'b0;
    pwm_value = 8'h00;
    sink_fault = 6'h00;
    over_temp = 1'b0;
    repeat (5) @(posedge ref_clk);
    #1;
    resetn = 1'b1;
    check({12'h000, rows}, 16'h0);
    check({11'h000, sink, sen, rate}, 16'h0);
    rdcheck(ADDR_THERMAL, RST_ZERO);
    rdcheck(ADDR_SPREAD, RST_ZERO);
    rdcheck(ADDR_RATE_SELECT, 8'h00);
    rdcheck(8'h70, 8'h00); // unmapped place reads zero
    // thresholds and derating, hot and cool
    for (int i = 0; i < 32; i++) begin
      over_temp = i[4];
      host.wr(ADDR_THERMAL, 8'(i[3:0]));
      tick();
      check(16'(thr), 16'(i[3:2]));
      check(16'(scale), i[4] ? 16'(i[1:0]) : 16'h0);
      rdcheck(ADDR_THERMAL, 8'(i[3:0]));
    end
    // every spread setting
    for (int i = 0; i < 32; i++) begin
      host.wr(ADDR_SPREAD, 8'(i));
      tick();
      check(16'(sen), 16'(i[4]));
      check(16'(srange), 16'(i[3:2]));
      check(16'(scycle), 16'(i[1:0]));
      rdcheck(ADDR_SPREAD, 8'(i));
    end
    // scan order and slot timing
    host.wr(ADDR_CONFIG, 8'h01);
    wait_while(4'h0, 2 * SLOT, n);
    cur = rows;
    wait_while(cur, SLOT, n);
    for (int k = 0; k < 5; k++) begin
      wait_while(4'h0, SLOT, n);
      check(16'(n), 16'(BLANK_A_CYC + BLANK_B_CYC));
      check({12'h000, rows}, {12'h000, cur[2:0], cur[3]});
      cur = rows;
      wait_while(cur, SLOT, n);
      check(16'(n), 16'(SCAN_CYC));
    end
    // shutdown darkens everything but keeps registers reachable
    pwm_value = 8'hff;
    host.wr(ADDR_CONFIG, 8'h00);
    tick();
    sample(1000, s, r);
    check(16'(s + r), 16'h0);
    rdcheck(ADDR_SPREAD, 8'h1f);
    // no-scan mode, duty from gamma table points
    host.wr(ADDR_CONFIG, {ROWSEL_NO_SCAN, 4'h1});
    // one whole slot per window, so it holds exactly one on-period
    for (int j = 0; j < 3; j++) begin
      pwm_value = n_g[j];
      tick();
      sample(SLOT, s, r);
      check(16'(r), 16'h0);
      check(16'((s >= n_g[j] * STEP) && (s <= n_g[j] * STEP + 3)), 16'h1);
    end
    // rate change only while unlocked
    host.wr(ADDR_RATE_SELECT, 8'ha0);
    tick();
    check(16'(rate), 16'h0);
    host.wr(ADDR_RATE_UNLOCK, 8'h01);
    for (int c = 0; c < 7; c++) begin
      host.wr(ADDR_RATE_SELECT, {c[2:0], 5'h00});
      tick();
      check(16'(rate), 16'(c[2:0]));
    end
    host.wr(ADDR_RATE_UNLOCK, 8'h00);
    host.wr(ADDR_RATE_SELECT, 8'h20);
    tick();
    check(16'(rate), 16'(RATE_SLOWEST));
    rdcheck(ADDR_RATE_UNLOCK, 8'h00);
    // open pass: all twelve flag registers fill
    sink_fault = 6'h2a;
    host.detect(DETECT_OPEN);
    repeat (12 * SLOT + 4) @(posedge ref_clk);
    for (int k = 0; k < 12; k++) begin
      rdcheck(ADDR_FAULT_FIRST + 8'(k), 8'h2a);
    end
    host.wr(ADDR_FAULT_FIRST, 8'hff);
    host.wr(ADDR_FAULT_LAST, 8'h00);
    rdcheck(ADDR_FAULT_FIRST, 8'h2a);
    rdcheck(ADDR_FAULT_LAST, 8'h2a);
    // short pass after clearing the field
    sink_fault = 6'h15;
    host.detect(DETECT_SHORT);
    repeat (8 * SLOT) @(posedge ref_clk);
    rdcheck(ADDR_FAULT_FIRST, 8'h15);
    // wrong key ignored, right key restores defaults
    host.wr(ADDR_SPREAD, 8'h1f);
    host.wr(ADDR_SOFT_RESET, 8'h55);
    tick();
    check(16'(sen), 16'h1);
    host.soft_reset();
    tick();
    tick();
    check({11'h000, sen, rows}, 16'h0);
    rdcheck(ADDR_SPREAD, RST_ZERO);
    rdcheck(ADDR_FAULT_FIRST, RST_ZERO);
    rdcheck(ADDR_SOFT_RESET, 8'h00);
    close_out();
  end
endmodule
`default_nettype wire

// ==== verilog/led_matrix_scan_pwm_control.sv ====
// led matrix scan, pwm and control/status registers of the matrix driver
// assumes a byte register port already decoded from the serial front end
`timescale 1ns/1ps
`default_nettype none
module led_matrix_scan_pwm_control #(
  parameter int unsigned DIV_W = 10
) (
  input wire logic i_ref_clk, // core clock, 100 MHz
  input wire logic i_resetn, // async reset, active low
  input wire logic i_wr_en, // register write strobe
  input wire logic i_rd_en, // register read strobe
  input wire logic [7:0] i_addr, // register address
  input wire logic [7:0] i_wdata, // write data
  input wire logic [7:0] i_pwm_value, // pwm value of the lit column group
  input wire logic [led_scan_pkg::FAULT_COLS-1:0] i_sink_fault, // analog fault sense
  input wire logic i_over_temp, // die at or over threshold
  output logic [7:0] o_rdata, // read data, registered
  output logic o_rd_valid, // read data valid pulse
  output logic [led_scan_pkg::ROWS-1:0] o_row_switch_output, // row switches, high on
  output logic o_column_sink_output, // column sinks enable
  output logic [1:0] o_rolloff_threshold, // thermal threshold select
  output logic [1:0] o_current_scale, // active derating code
  output logic o_spread_enable, // clock spreading on
  output logic [1:0] o_spread_range, // spread deviation select
  output logic [1:0] o_spread_cycle, // spread period select
  output logic [2:0] o_pwm_rate_code // active pwm rate
);
  import led_scan_pkg::*;

  // every piece of state except the step timer's in one struct
  typedef struct packed {
    logic [7:0] config_reg;
    logic [7:0] gcurrent;
    logic [7:0] pullsel;
    logic [FAULT_REGS-1:0][FAULT_COLS-1:0] faults;
    logic [3:0] thermal;
    logic [4:0] spread;
    logic unlock;
    logic [2:0] rate;
    logic [1:0] detect_prev;
    logic detect_busy;
    logic [1:0] detect_kind;
    logic [3:0] detect_idx;
    phase_t phase;
    logic [15:0] slot_cnt;
    logic [1:0] row;
    logic [8:0] pwm_cnt;
    logic [7:0] rdata;
    logic rd_valid;
    logic [ROWS-1:0] row_out;
    logic sink_on;
    logic [1:0] scale;
  } state_t;

  state_t st_ff;
  state_t nxt_st;
  logic pwm_step;
  logic slot_start;

  // returns true for an address in the fault flag window
  function automatic logic is_fault_addr(input logic [7:0] a);
    return (a >= ADDR_FAULT_FIRST) && (a <= ADDR_FAULT_LAST);
  endfunction

  // last row in use for the selected row mode
  function automatic logic [1:0] last_row(input logic [3:0] m);
    case (m)
      ROWSEL_THREE: return 2'h2;
      ROWSEL_TWO: return 2'h1;
      default: return 2'h3;
    endcase
  endfunction

  // a slot starts when the scan phase is entered
  assign slot_start = (st_ff.phase == PH_BLANK_B) &&
                      (st_ff.slot_cnt == 16'(BLANK_B_CYC - 1));

  pwm_step_timer #(
    .DIV_W(DIV_W)
  ) u_step (
    .i_ref_clk(i_ref_clk),
    .i_resetn(i_resetn),
    .i_restart(slot_start),
    .i_rate_code(st_ff.rate),
    .o_step(pwm_step)
  );

  // next-state logic: registers, detection, scan sequencing, outputs
  always_comb begin
    logic [3:0] mode;
    logic shutdown;
    logic [3:0] fidx;
    mode = st_ff.config_reg[CFG_ROWSEL_LSB +: 4];
    shutdown = ~st_ff.config_reg[CFG_SHUTDOWN_BIT];
    fidx = 4'(i_addr - ADDR_FAULT_FIRST);
    nxt_st = st_ff;
    nxt_st.rd_valid = 1'b0;

    // register writes
    if (i_wr_en) begin
      case (i_addr)
        ADDR_CONFIG: nxt_st.config_reg = i_wdata;
        ADDR_GCURRENT: nxt_st.gcurrent = i_wdata;
        ADDR_PULLSEL: nxt_st.pullsel = i_wdata;
        ADDR_THERMAL: nxt_st.thermal = i_wdata[3:0];
        ADDR_SPREAD: nxt_st.spread = i_wdata[4:0];
        ADDR_RATE_UNLOCK: nxt_st.unlock = i_wdata[0];
        ADDR_RATE_SELECT: begin
          // locked writes leave the rate alone
          if (st_ff.unlock) begin
            nxt_st.rate = i_wdata[RATE_CODE_LSB +: 3];
          end
        end
        default: begin
          // fault window and unmapped addresses store nothing
        end
      endcase
    end

    // read path, reserved bits as zero
    if (i_rd_en) begin
      nxt_st.rd_valid = 1'b1;
      if (is_fault_addr(i_addr)) begin
        nxt_st.rdata = {2'b00, st_ff.faults[fidx]};
      end else begin
        case (i_addr)
          ADDR_CONFIG: nxt_st.rdata = st_ff.config_reg;
          ADDR_GCURRENT: nxt_st.rdata = st_ff.gcurrent;
          ADDR_PULLSEL: nxt_st.rdata = st_ff.pullsel;
          ADDR_THERMAL: nxt_st.rdata = {4'h0, st_ff.thermal};
          ADDR_SPREAD: nxt_st.rdata = {3'h0, st_ff.spread};
          default: nxt_st.rdata = 8'h00;
        endcase
      end
    end

    // detection trigger on a fresh 01, 10 or 11 code (11 runs as open), once per arming
    // previous field value, so a fresh code is seen one cycle after the write
    nxt_st.detect_prev = st_ff.config_reg[CFG_DETECT_LSB +: 2];
    if (!st_ff.detect_busy && (st_ff.detect_prev == 2'h0)) begin
      if (st_ff.config_reg[CFG_DETECT_LSB +: 2] == DETECT_OPEN ||
          st_ff.config_reg[CFG_DETECT_LSB +: 2] == 2'h3) begin
        nxt_st.detect_busy = 1'b1;
        nxt_st.detect_kind = DETECT_OPEN;
        nxt_st.detect_idx = 4'h0;
      end else if (st_ff.config_reg[CFG_DETECT_LSB +: 2] == DETECT_SHORT) begin
        nxt_st.detect_busy = 1'b1;
        nxt_st.detect_kind = DETECT_SHORT;
        nxt_st.detect_idx = 4'h0;
      end
    end
    // one flag register captured per scan phase end
    if (st_ff.detect_busy && st_ff.phase == PH_SCAN &&
        st_ff.slot_cnt == 16'(SCAN_CYC - 1)) begin
      nxt_st.faults[st_ff.detect_idx] = i_sink_fault;
      if (st_ff.detect_idx == 4'(FAULT_REGS - 1)) begin
        nxt_st.detect_busy = 1'b0;
      end else begin
        nxt_st.detect_idx = 4'(st_ff.detect_idx + 4'h1);
      end
    end

    // slot sequencer: scan, blank a, blank b
    nxt_st.slot_cnt = 16'(st_ff.slot_cnt + 16'h1);
    case (st_ff.phase)
      PH_SCAN: begin
        if (st_ff.slot_cnt == 16'(SCAN_CYC - 1)) begin
          nxt_st.phase = PH_BLANK_A;
          nxt_st.slot_cnt = 16'h0;
        end
      end
      PH_BLANK_A: begin
        if (st_ff.slot_cnt == 16'(BLANK_A_CYC - 1)) begin
          nxt_st.phase = PH_BLANK_B;
          nxt_st.slot_cnt = 16'h0;
        end
      end
      PH_BLANK_B: begin
        if (slot_start) begin
          nxt_st.phase = PH_SCAN;
          nxt_st.slot_cnt = 16'h0;
          nxt_st.pwm_cnt = 9'h0;
          // serial order, wrapping after the last used row
          nxt_st.row = (st_ff.row >= last_row(mode)) ? 2'h0 :
                       2'(st_ff.row + 2'h1);
        end
      end
      default: begin
        nxt_st.phase = PH_SCAN;
        nxt_st.slot_cnt = 16'h0;
      end
    endcase

    // pwm step counter within a slot, saturating at 256
    if (pwm_step && st_ff.phase == PH_SCAN && st_ff.pwm_cnt < 9'(PWM_STEPS)) begin
      nxt_st.pwm_cnt = 9'(st_ff.pwm_cnt + 9'h1);
    end

    // outputs
    nxt_st.row_out = '0;
    if (!shutdown && mode != ROWSEL_NO_SCAN && st_ff.phase == PH_SCAN) begin
      nxt_st.row_out[st_ff.row] = 1'b1;
    end
    // sink on while the step count is below the pwm value
    nxt_st.sink_on = !shutdown &&
                     (mode == ROWSEL_NO_SCAN || st_ff.phase == PH_SCAN) &&
                     (st_ff.pwm_cnt < {1'b0, i_pwm_value});
    // derating applies only once the die is hot
    nxt_st.scale = i_over_temp ? st_ff.thermal[1:0] : 2'h0;

    // soft reset key overrides everything
    if (i_wr_en && i_addr == ADDR_SOFT_RESET && i_wdata == SOFT_RESET_KEY) begin
      nxt_st = '0;
      nxt_st.pullsel = RST_PULLSEL;
      nxt_st.phase = PH_SCAN;
    end
  end

  // state register; reset gives a blank display
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_ff <= '0;
      st_ff.pullsel <= RST_PULLSEL;
      st_ff.phase <= PH_SCAN;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_rdata = st_ff.rdata;
  assign o_rd_valid = st_ff.rd_valid;
  assign o_row_switch_output = st_ff.row_out;
  assign o_column_sink_output = st_ff.sink_on;
  assign o_rolloff_threshold = st_ff.thermal[3:2];
  assign o_current_scale = st_ff.scale;
  assign o_spread_enable = st_ff.spread[SPREAD_EN_BIT];
  assign o_spread_range = st_ff.spread[3:2];
  assign o_spread_cycle = st_ff.spread[1:0];
  assign o_pwm_rate_code = st_ff.rate;

  // assertions
  locked_rate_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (i_wr_en && i_addr == ADDR_RATE_SELECT && !st_ff.unlock)
    |=> $stable(o_pwm_rate_code)) else $error("rate changed while locked");
  soft_reset_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (i_wr_en && i_addr == ADDR_SOFT_RESET && i_wdata == SOFT_RESET_KEY)
    |=> (o_spread_enable == 1'b0 && o_pwm_rate_code == 3'h0)) else $error("soft reset");
  shutdown_dark_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (!st_ff.config_reg[CFG_SHUTDOWN_BIT] && !nxt_st.config_reg[CFG_SHUTDOWN_BIT])
    |=> (!o_column_sink_output && o_row_switch_output == '0)) else $error("lit in shutdown");
  one_row_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    $onehot0(o_row_switch_output)) else $error("rows overlap");
  blank_rows_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (st_ff.phase != PH_SCAN) |=> (o_row_switch_output == '0)) else $error("row in blank");
  fault_ro_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (!st_ff.detect_busy && !nxt_st.detect_busy && !(i_wr_en && i_addr == ADDR_SOFT_RESET))
    |=> $stable(st_ff.faults)) else $error("flags changed idle");
  fault_read_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (i_rd_en && is_fault_addr(i_addr)) |=> (o_rd_valid && o_rdata[7:6] == 2'b00))
    else $error("fault read upper bits");
  no_scan_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (st_ff.config_reg[CFG_ROWSEL_LSB +: 4] == ROWSEL_NO_SCAN)
    |=> (o_row_switch_output == '0)) else $error("scan in sink mode");
  derate_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    !i_over_temp |=> (o_current_scale == 2'h0)) else $error("derate while cool");
  // main scenarios
  cov_detect_c: cover property (@(posedge i_ref_clk) disable iff (!i_resetn)
    st_ff.detect_busy ##1 !st_ff.detect_busy);
  cov_unlock_c: cover property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (i_wr_en && i_addr == ADDR_RATE_SELECT && st_ff.unlock));
  cov_row3_c: cover property (@(posedge i_ref_clk) disable iff (!i_resetn)
    o_row_switch_output[3]);
  cov_reset_c: cover property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (i_wr_en && i_addr == ADDR_SOFT_RESET && i_wdata == SOFT_RESET_KEY));
endmodule
`default_nettype wire

// ==== verilog/pwm_step_timer.sv ====
// pwm step timer: emits one step pulse per rate-dependent prescale period
// assumes the scan slot length is long enough for 256 steps at rate code 0
`timescale 1ns/1ps
`default_nettype none
module pwm_step_timer #(
  parameter int unsigned DIV_W = 10
) (
  input wire logic i_ref_clk, // core clock
  input wire logic i_resetn, // async reset, active low
  input wire logic i_restart, // restart at slot start
  input wire logic [2:0] i_rate_code, // selected pwm rate
  output logic o_step // one-cycle step pulse
);
  import led_scan_pkg::*;
  // base prescale spreads 256 steps over one scan phase at rate code 0
  // slower codes run past the scan phase, so long on-times clip at its end except in no-scan mode, where the sink stays on through the blanks
  localparam int unsigned BASE_CYC = SCAN_CYC / PWM_STEPS;
  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic step;
  } tmr_t;
  tmr_t st_ff;
  tmr_t nxt_st;
  logic [2:0] eff_code;
  logic [DIV_W-1:0] limit;
  // code 111 behaves as the slowest rate
  assign eff_code = (i_rate_code > RATE_SLOWEST) ? RATE_SLOWEST : i_rate_code;
  // each code halves the rate, so the prescale doubles
  assign limit = DIV_W'((DIV_W'(BASE_CYC) << eff_code) - DIV_W'(1));
  // next-state logic
  always_comb begin
    nxt_st = st_ff;
    nxt_st.step = 1'b0;
    if (i_restart) begin
      nxt_st.cnt = '0;
    end else if (st_ff.cnt >= limit) begin
      nxt_st.cnt = '0;
      nxt_st.step = 1'b1;
    end else begin
      nxt_st.cnt = DIV_W'(st_ff.cnt + DIV_W'(1));
    end
  end
  // state register
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign o_step = st_ff.step;
endmodule
`default_nettype wire
